// File: hw/thermal_store.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "thermal_store_cfg.svh"
module thermal_store
    import thermal_store_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Alert pin
    input wire logic alert_n_in,
    output logic alert_n_out,
    output logic alert_n_oe,
    // Temperature samples
    input wire logic temp_valid,
    input wire logic [7:0] temp_code,
    // Register port
    input wire reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
logic [2:0] scl_sync_ff;
logic [2:0] sda_sync_ff;
logic scl_ff;
logic sda_ff;
logic scl_stable;
logic sda_stable;
logic scl_rise;
logic scl_fall;
logic start_det;
logic stop_det;

always_ff @(posedge clk) begin
    if (srst) begin
        scl_sync_ff <= 3'h7;
        sda_sync_ff <= 3'h7;
    end else begin
        scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
        sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
end

// Sampling at 200 MHz leaves wide margin for a 1 MHz serial clock
assign scl_stable = scl_sync_ff[1] == scl_sync_ff[2];
assign sda_stable = sda_sync_ff[1] == sda_sync_ff[2];
assign scl_rise = scl_stable && scl_sync_ff[2] && !scl_ff;
assign scl_fall = scl_stable && !scl_sync_ff[2] && scl_ff;
assign start_det = scl_ff && scl_stable && scl_sync_ff[2] && sda_ff &&
    sda_stable && !sda_sync_ff[2];
assign stop_det = scl_ff && scl_stable && scl_sync_ff[2] && !sda_ff &&
    sda_stable && sda_sync_ff[2];

always_ff @(posedge clk) begin
    if (srst) begin
        scl_ff <= 1'b1;
        sda_ff <= 1'b1;
    end else begin
        if (scl_stable) begin
            scl_ff <= scl_sync_ff[2];
        end
        if (sda_stable) begin
            sda_ff <= sda_sync_ff[2];
        end
    end
end

// ----------------------------------------
// Serial target state
// ----------------------------------------
i2c_state_t st_ff;
logic [3:0] cnt_ff;
logic [7:0] sh_ff;
logic [7:0] tx_ff;
logic [7:0] ptr_ff;
logic hi_ff;
logic sel_store_ff;
logic nack_ff;
logic sda_oe_ff;
logic sda_out_ff;
typedef logic [7:0] store_mem_t [0:`ST_DEPTH-1];

// Factory image, lower blocks pre-programmed
function automatic store_mem_t factory_image();
    store_mem_t img;
    for (int i = 0; i < `ST_DEPTH; i++) begin
        img[i] = (i < `PROT_LIMIT) ? `FACTORY_BYTE : `BLANK_BYTE;
    end
    return img;
endfunction

store_mem_t mem = factory_image();
logic [8:0] st_addr;
logic [7:0] rd_byte;
logic wr_fire;
logic prot;
logic [3:0] wp_ext;
logic ts_hit;
logic st_hit;
logic clear_evt;

// Sensor registers
alert_mode_t mode_ff;
logic [7:0] upper_ff;
logic [7:0] lower_ff;
logic [7:0] crit_ff;
logic [7:0] hyst_ff;
logic [2:0] wp_ff;
logic [7:0] temp_ff;
logic event_ff;
logic crit_hold_ff;

assign st_addr = {hi_ff, ptr_ff};
assign ts_hit = sh_ff[7:1] == `TS_DEV_ADDR;
assign st_hit = sh_ff[7:2] == `ST_DEV_BASE;
assign wr_fire = scl_fall && cnt_ff == `BIT_CNT_DATA && st_ff == I2C_WR;
assign wp_ext = {1'b0, wp_ff};
// Block index is the top two address bits
assign prot = st_addr < `PROT_LIMIT && wp_ext[st_addr[8:7]];
assign clear_evt = wr_fire && !sel_store_ff && ptr_ff == `PTR_STATUS &&
    sh_ff[0];

// Byte returned to the host
always_comb begin
    rd_byte = 8'h00;
    if (sel_store_ff) begin
        if (st_addr < `RSVD_LO || st_addr > `RSVD_HI) begin
            rd_byte = mem[st_addr];
        end
    end else begin
        case (ptr_ff)
            `PTR_CONFIG: rd_byte = {6'h00, mode_ff};
            `PTR_UPPER: rd_byte = upper_ff;
            `PTR_LOWER: rd_byte = lower_ff;
            `PTR_CRIT: rd_byte = crit_ff;
            `PTR_TEMP: rd_byte = temp_ff;
            `PTR_STATUS: rd_byte = {6'h00, crit_hold_ff, event_ff};
            `PTR_HYST: rd_byte = hyst_ff;
            `PTR_WPROT: rd_byte = {5'h00, wp_ff};
            default: rd_byte = 8'h00;
        endcase
    end
end

// Bit engine driven by serial clock edges and by start and stop conditions
always_ff @(posedge clk) begin
    if (srst) begin
        st_ff <= I2C_IDLE;
        cnt_ff <= 4'h0;
        sh_ff <= 8'h00;
        tx_ff <= 8'h00;
        ptr_ff <= 8'h00;
        hi_ff <= 1'b0;
        sel_store_ff <= 1'b0;
        nack_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
    end else if (start_det) begin
        st_ff <= I2C_ADDR;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
        st_ff <= I2C_IDLE;
        sda_oe_ff <= 1'b0;
    end else if (st_ff != I2C_IDLE && scl_rise) begin
        if (cnt_ff < `BIT_CNT_DATA) begin
            sh_ff <= {sh_ff[6:0], sda_ff};
        end else if (st_ff == I2C_RD) begin
            nack_ff <= sda_ff;
        end
        cnt_ff <= cnt_ff + 4'h1;
    end else if (st_ff != I2C_IDLE && scl_fall) begin
        if (cnt_ff == `BIT_CNT_DATA) begin
            sda_oe_ff <= st_ff != I2C_RD;
            case (st_ff)
                I2C_ADDR: begin
                    if (ts_hit || st_hit) begin
                        sel_store_ff <= st_hit;
                        hi_ff <= st_hit && sh_ff[1];
                        nack_ff <= 1'b0;
                        st_ff <= sh_ff[0] ? I2C_RD : I2C_PTR;
                    end else begin
                        sda_oe_ff <= 1'b0;
                        st_ff <= I2C_IDLE;
                    end
                end
                I2C_PTR: begin
                    ptr_ff <= sh_ff;
                    st_ff <= I2C_WR;
                end
                I2C_WR: begin
                    // Acked even when the byte is protected
                    ptr_ff <= ptr_ff + 8'h01;
                end
                default: begin
                end
            endcase
        end else if (cnt_ff == `BIT_CNT_ACK) begin
            cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            if (st_ff == I2C_RD) begin
                if (nack_ff) begin
                    st_ff <= I2C_IDLE;
                end else begin
                    tx_ff <= rd_byte;
                    ptr_ff <= ptr_ff + 8'h01;
                    sda_oe_ff <= !rd_byte[7];
                end
            end
        end else if (st_ff == I2C_RD) begin
            sda_oe_ff <= !tx_ff[3'h7 - cnt_ff[2:0]];
        end
    end
end

always_ff @(posedge clk) begin
    if (srst) begin
        sda_out_ff <= 1'b0;
    end else begin
        sda_out_ff <= 1'b0;
    end
end

// ----------------------------------------
// Configuration store
// ----------------------------------------
always_ff @(posedge clk) begin
    if (wr_fire && sel_store_ff && !prot) begin
        mem[st_addr] <= sh_ff;
    end
end

// ----------------------------------------
// Sensor registers
// ----------------------------------------
always_ff @(posedge clk) begin
    if (srst) begin
        mode_ff <= MODE_INT;
        upper_ff <= `RST_UPPER;
        lower_ff <= `RST_LOWER;
        crit_ff <= `RST_CRIT;
        hyst_ff <= `RST_HYST;
        wp_ff <= `RST_WPROT;
    end else if (wr_fire && !sel_store_ff) begin
        case (ptr_ff)
            `PTR_CONFIG: begin
                if (sh_ff[1:0] != 2'h3) begin
                    mode_ff <= alert_mode_t'(sh_ff[1:0]);
                end
            end
            `PTR_UPPER: upper_ff <= sh_ff;
            `PTR_LOWER: lower_ff <= sh_ff;
            `PTR_CRIT: crit_ff <= sh_ff;
            `PTR_HYST: hyst_ff <= sh_ff;
            `PTR_WPROT: wp_ff <= sh_ff[2:0];
            default: begin
            end
        endcase
    end
end

always_ff @(posedge clk) begin
    if (srst) begin
        temp_ff <= 8'h00;
    end else if (temp_valid) begin
        temp_ff <= temp_code;
    end
end

// ----------------------------------------
// Alert logic
// ----------------------------------------
logic window_err;
logic [7:0] crit_low;
logic nxt_alert;
logic alert_oe_ff;
logic alert_out_ff;

assign window_err = temp_ff > upper_ff || temp_ff < lower_ff;
assign crit_low = (crit_ff > hyst_ff) ? crit_ff - hyst_ff : 8'h00;

always_ff @(posedge clk) begin
    if (srst) begin
        crit_hold_ff <= 1'b0;
    end else if (temp_ff > crit_ff) begin
        crit_hold_ff <= 1'b1;
    end else if (temp_ff < crit_low) begin
        crit_hold_ff <= 1'b0;
    end
end

always_ff @(posedge clk) begin
    if (srst) begin
        event_ff <= 1'b0;
    end else if (mode_ff == MODE_INT && window_err) begin
        event_ff <= 1'b1;
    end else if (clear_evt || mode_ff != MODE_INT) begin
        event_ff <= 1'b0;
    end
end

always_comb begin
    case (mode_ff)
        MODE_INT: nxt_alert = event_ff || crit_hold_ff;
        MODE_CMP: nxt_alert = window_err || crit_hold_ff;
        MODE_CRIT: nxt_alert = crit_hold_ff;
        default: nxt_alert = 1'b0;
    endcase
end

always_ff @(posedge clk) begin
    if (srst) begin
        alert_oe_ff <= 1'b0;
        alert_out_ff <= 1'b0;
    end else begin
        alert_oe_ff <= nxt_alert;
        alert_out_ff <= 1'b0;
    end
end

// ----------------------------------------
// Register port and interrupt
// ----------------------------------------
logic [`STS_W-1:0] sts_ff;
logic [`STS_W-1:0] mask_ff;
logic [`STS_W-1:0] sts_set;
logic [`STS_W-1:0] sts_clr;
logic [31:0] rdata_ff;
logic irq_ff;

assign sts_set = {wr_fire && sel_store_ff && prot, nxt_alert && !alert_oe_ff};
assign sts_clr = (reg_req.wr && reg_req.addr == `REG_STATUS) ?
    reg_req.wdata[`STS_W-1:0] : {`STS_W{1'b0}};

always_ff @(posedge clk) begin
    if (srst) begin
        sts_ff <= {`STS_W{1'b0}};
        mask_ff <= {`STS_W{1'b0}};
        irq_ff <= 1'b0;
    end else begin
        sts_ff <= (sts_ff & ~sts_clr) | sts_set;
        if (reg_req.wr && reg_req.addr == `REG_MASK) begin
            mask_ff <= reg_req.wdata[`STS_W-1:0];
        end
        irq_ff <= |(sts_ff & mask_ff);
    end
end

always_ff @(posedge clk) begin
    if (srst) begin
        rdata_ff <= 32'h0000_0000;
    end else if (reg_req.rd) begin
        case (reg_req.addr)
            `REG_STATUS: rdata_ff <= {30'h0, sts_ff};
            `REG_MASK: rdata_ff <= {30'h0, mask_ff};
            `REG_TEMP: rdata_ff <= {24'h0, temp_ff};
            default: rdata_ff <= 32'h0000_0000;
        endcase
    end else begin
        rdata_ff <= 32'h0000_0000;
    end
end

assign sda_out = sda_out_ff;
assign sda_oe = sda_oe_ff;
assign alert_n_out = alert_out_ff;
assign alert_n_oe = alert_oe_ff;
assign reg_rdata = rdata_ff;
assign irq = irq_ff;

// ----------------------------------------
// Checks
// ----------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (srst);

chk_temp_track: assert property (
    temp_valid |=> temp_ff == $past(temp_code))
    else $error("temperature not refreshed");
chk_temp_read: assert property (
    st_ff == I2C_RD && scl_fall && cnt_ff == `BIT_CNT_ACK && !nack_ff &&
    !sel_store_ff && ptr_ff == `PTR_TEMP |=> tx_ff == $past(temp_ff))
    else $error("temperature read wrong");
chk_alert_drive: assert property (
    nxt_alert |=> alert_n_oe && !alert_n_out)
    else $error("alert not driven low");
chk_alert_source: assert property (
    alert_n_oe |-> $past(event_ff) || $past(crit_hold_ff) ||
    $past(window_err))
    else $error("alert without sensor cause");
chk_int_latch: assert property (
    mode_ff == MODE_INT && event_ff && !clear_evt ##1
    mode_ff == MODE_INT |-> event_ff ##1 alert_n_oe)
    else $error("interrupt alert dropped");
chk_cmp_clear: assert property (
    mode_ff == MODE_CMP && !window_err && !crit_hold_ff |=> !alert_n_oe)
    else $error("comparator alert stuck");
chk_crit_cmp: assert property (
    crit_hold_ff |=> alert_n_oe)
    else $error("critical alert missing");
chk_crit_only: assert property (
    mode_ff == MODE_CRIT && temp_ff > crit_ff |=> ##1 alert_n_oe)
    else $error("critical-only alert late");
chk_rsvd_zero: assert property (
    sel_store_ff && st_addr >= `RSVD_LO && st_addr <= `RSVD_HI |->
    rd_byte == 8'h00)
    else $error("reserved byte not zero");
chk_prot_ack: assert property (
    wr_fire |=> sda_oe ##1 sts_ff[`STS_PROT] ==
    ($past(prot, 2) && $past(sel_store_ff, 2)) ||
    $past(sts_ff[`STS_PROT]))
    else $error("write not acked");
chk_stop_idle: assert property (
    stop_det |=> st_ff == I2C_IDLE && !sda_oe)
    else $error("stop not honoured");

cov_store_write: cover property (wr_fire && sel_store_ff && !prot);
cov_prot_write: cover property (wr_fire && sel_store_ff && prot);
cov_temp_read: cover property (st_ff == I2C_RD && !sel_store_ff ##1
    st_ff == I2C_IDLE);
cov_irq: cover property ($rose(irq));

endmodule

// File: hw/thermal_store_cfg.svh
`ifndef THERMAL_STORE_CFG_SVH
`define THERMAL_STORE_CFG_SVH
// ----------------------------------------
// Serial bus addresses and timing
// ----------------------------------------
`define TS_DEV_ADDR 7'h18
`define ST_DEV_BASE 6'h28
`define CLK_PERIOD_NS 5
`define SCL_PERIOD_NS 1000
`define SCL_HALF_CYC ((`SCL_PERIOD_NS / 2) / `CLK_PERIOD_NS)
// ----------------------------------------
// Sensor register pointers
// ----------------------------------------
`define PTR_CONFIG 8'h01
`define PTR_UPPER 8'h02
`define PTR_LOWER 8'h03
`define PTR_CRIT 8'h04
`define PTR_TEMP 8'h05
`define PTR_STATUS 8'h06
`define PTR_HYST 8'h07
`define PTR_WPROT 8'h08
// ----------------------------------------
// Sensor reset values
// ----------------------------------------
`define RST_UPPER 8'h50
`define RST_LOWER 8'h00
`define RST_CRIT 8'h5f
`define RST_HYST 8'h02
`define RST_WPROT 3'h7
// ----------------------------------------
// Store layout
// ----------------------------------------
`define ST_DEPTH 512
`define PROT_LIMIT 9'h180
`define RSVD_LO 9'h100
`define RSVD_HI 9'h13f
`define FACTORY_BYTE 8'ha5
`define BLANK_BYTE 8'hff
// ----------------------------------------
// Register port map and serial bit counts
// ----------------------------------------
`define REG_STATUS 4'h0
`define REG_MASK 4'h4
`define REG_TEMP 4'h8
`define STS_ALERT 0
`define STS_PROT 1
`define STS_W 2
`define BIT_CNT_DATA 4'h8
`define BIT_CNT_ACK 4'h9
`endif

// File: hw/thermal_store_pkg.sv
package thermal_store_pkg;
    typedef enum logic [1:0] {
        MODE_INT,
        MODE_CMP,
        MODE_CRIT
    } alert_mode_t;
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_PTR,
        I2C_WR,
        I2C_RD
    } i2c_state_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// File: sim/i2c_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host bus controller model
// ----------------------------------------
module i2c_host (
    // Serial bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // Quarter of an 80 ns serial period, well above 1 MHz
    localparam int Q = 20;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Start or repeated start, SDA falls while SCL high
    task automatic start_c();
        #Q sda_pull <= 1'b0;
        #Q scl <= 1'b1;
        #Q sda_pull <= 1'b1;
        #Q scl <= 1'b0;
    endtask

    task automatic stop_c();
        #Q sda_pull <= 1'b1;
        #Q scl <= 1'b1;
        #Q sda_pull <= 1'b0;
        #Q;
    endtask

    // One clock: data set while low, sampled mid high phase
    task automatic bit_x(input logic b, output logic s);
        #Q sda_pull <= ~b;
        #Q scl <= 1'b1;
        #Q s = sda;
        #Q scl <= 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(nack, s);
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/100ps
`include "thermal_store_cfg.svh"
module tb_top
    import thermal_store_pkg::*;
;
    localparam logic [6:0] ts_addr = `TS_DEV_ADDR;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic scl;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic alert_n_out;
    logic alert_n_oe;
    logic temp_valid = 1'b0;
    logic [7:0] temp_code = 8'h00;
    reg_req_t reg_req = '0;
    logic [31:0] reg_rdata;
    logic irq;
    logic rd_d = 1'b0;
    logic [31:0] seed = 32'h5ebf;
    logic [31:0] exp_q[$];
    logic [31:0] obs_q[$];
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [8:0] sa [5] = '{9'h000, 9'h17f, 9'h100, 9'h13f, 9'h180};
    logic [7:0] se [5] = '{`FACTORY_BYTE, `FACTORY_BYTE, 8'h00, 8'h00,
                           `BLANK_BYTE};
    wire sda = ~(sda_pull | (sda_oe & ~sda_out));
    wire alert_n = ~(alert_n_oe & ~alert_n_out);

    always #2.5 clk = ~clk;

    thermal_store i_dut (
        .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .alert_n_in(alert_n),
        .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .temp_valid(temp_valid), .temp_code(temp_code),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq)
    );
    i2c_host h (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [6:0] sdev(input logic [8:0] x);
        return {`ST_DEV_BASE, x[8]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (exp_q.size() != obs_q.size()) begin
            err_total++;
        end
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic look(input logic [31:0] s, input logic [31:0] e);
        exp_q.push_back(e);
        obs_q.push_back(s);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic temp(input logic [7:0] t);
        @(posedge clk);
        temp_valid <= 1'b1;
        temp_code <= t;
        @(posedge clk);
        temp_valid <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic i2c_wr(input logic [6:0] dv, input logic [7:0] p,
                          input logic [7:0] d);
        logic a;
        h.start_c();
        h.wbyte({dv, 1'b0}, a);
        look({31'h0, a}, 32'h1);
        h.wbyte(p, a);
        h.wbyte(d, a);
        look({31'h0, a}, 32'h1);
        h.stop_c();
    endtask

    task automatic i2c_rd(input logic [6:0] dv, input logic [7:0] p,
                          input logic [7:0] e);
        logic a;
        logic [7:0] b;
        h.start_c();
        h.wbyte({dv, 1'b0}, a);
        h.wbyte(p, a);
        h.start_c();
        h.wbyte({dv, 1'b1}, a);
        h.rbyte(1'b1, b);
        h.stop_c();
        look({24'h0, b}, {24'h0, e});
    endtask

    // ----------------------------------------
    // Result watcher and timeout
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (rd_d) begin
            obs_q.push_back(reg_rdata);
        end
        rd_d <= reg_req.rd;
        while (exp_q.size() > 0 && obs_q.size() > 0) begin
            chk(obs_q.pop_front(), exp_q.pop_front());
        end
        if (cycles == 60000) begin
            err_total++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] t;
        logic a;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        look({29'h0, irq, alert_n_oe, sda_oe}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            t = 8'(rnd() & 32'h3f);
            temp(t);
            reg_rd(`REG_TEMP, {24'h0, t}); // Latest sample
        end
        i2c_rd(ts_addr, `PTR_TEMP, t); // Serial temp
        i2c_rd(ts_addr, `PTR_CRIT, `RST_CRIT); // Limit reg
        reg_wr(4'hc, rnd());
        reg_rd(4'hc, 32'h0);
        // Latched interrupt style
        i2c_wr(ts_addr, `PTR_CONFIG, 8'h00);
        reg_wr(`REG_MASK, 32'h1);
        temp(8'h55);
        look({31'h0, ~alert_n}, 32'h1); // Low pin
        temp(8'h30);
        look({31'h0, ~alert_n}, 32'h1); // Still held
        reg_rd(`REG_STATUS, 32'h1);
        look({31'h0, irq}, 32'h1);
        reg_wr(`REG_STATUS, 32'h1);
        look({31'h0, irq}, 32'h0);
        i2c_wr(ts_addr, `PTR_STATUS, 8'h01); // Host clear
        repeat (8) @(posedge clk);
        look({31'h0, ~alert_n}, 32'h0); // Released
        // Comparator style, interrupt masked then unmasked
        reg_wr(`REG_MASK, 32'h0);
        i2c_wr(ts_addr, `PTR_CONFIG, 8'h01);
        temp(8'h55);
        look({31'h0, ~alert_n}, 32'h1); // Set
        look({31'h0, irq}, 32'h0);
        reg_wr(`REG_MASK, 32'h1);
        look({31'h0, irq}, 32'h1);
        temp(8'h30);
        look({31'h0, ~alert_n}, 32'h0); // Self clear
        reg_wr(`REG_STATUS, 32'h1);
        look({31'h0, irq}, 32'h0);
        i2c_wr(ts_addr, `PTR_CONFIG, 8'h03);
        i2c_rd(ts_addr, `PTR_CONFIG, 8'h01); // Mode 3 refused
        // Critical-only style at the limit edges
        i2c_wr(ts_addr, `PTR_CONFIG, 8'h02);
        temp(`RST_CRIT);
        look({31'h0, ~alert_n}, 32'h0); // At limit
        temp(`RST_CRIT + 8'h01);
        look({31'h0, ~alert_n}, 32'h1); // Above limit
        temp(`RST_CRIT - `RST_HYST);
        look({31'h0, ~alert_n}, 32'h1); // Hysteresis
        temp(`RST_CRIT - `RST_HYST - 8'h01);
        look({31'h0, ~alert_n}, 32'h0); // Clears
        // Store layout and protection
        reg_wr(`REG_STATUS, 32'h3);
        for (int i = 0; i < 5; i++) begin
            i2c_rd(sdev(sa[i]), sa[i][7:0], se[i]);
        end
        t = 8'(rnd());
        i2c_wr(sdev(9'h0ff), 8'hff, t); // Acked anyway
        i2c_rd(sdev(9'h0ff), 8'hff, `FACTORY_BYTE); // Kept
        reg_rd(`REG_STATUS, 32'h2); // Drop flagged
        reg_wr(`REG_MASK, 32'h2);
        look({31'h0, irq}, 32'h1);
        i2c_wr(sdev(9'h1ff), 8'hff, t);
        i2c_rd(sdev(9'h1ff), 8'hff, t); // Top block open
        i2c_wr(ts_addr, `PTR_WPROT, 8'h00);
        i2c_wr(sdev(9'h0ff), 8'hff, ~t);
        i2c_rd(sdev(9'h0ff), 8'hff, ~t); // Reversible
        look({31'h0, ~alert_n}, 32'h0); // Store quiet
        h.start_c();
        h.wbyte({7'h33, 1'b0}, a);
        look({31'h0, a}, 32'h0); // Foreign address
        h.stop_c();
        repeat (20) @(posedge clk);
        end_sim();
    end
endmodule
